// ===== ccu_defines.svh
// Register map, reset values and timing counts of the checksum unit
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

`define CCU_BASE_ADDR      32'h4002_3000
`define CCU_OFS_ACC        32'h0000_0000
`define CCU_OFS_SCRATCH    32'h0000_0004
`define CCU_OFS_CTRL       32'h0000_0008
`define CCU_ADDR_MASK      32'hFFFF_FFF0
`define CCU_ACC_RESET      32'hFFFF_FFFF
`define CCU_SCRATCH_RESET  8'h00
`define CCU_POLY           32'h04C1_1DB7
`define CCU_CTRL_REINIT    0
`define CCU_SCRATCH_MSB    7
`define CCU_CALC_CYCLES    3'h4
`define CCU_BITS_PER_STEP  8
`define CCU_HSIZE_WORD     3'h2
`define CCU_HTRANS_NONSEQ  2'h2
`define CCU_HTRANS_SEQ     2'h3

`endif

// ===== ccu_pkg.sv
// Types shared by the checksum unit files
`include "ccu_defines.svh"
package ccu_pkg;
    typedef enum logic [1:0] {
        CCU_IDLE,
        CCU_CALC
    } ccu_state_e;

    typedef struct packed {
        logic        write;
        logic [31:0] addr;
    } ccu_req_s;
endpackage

// ===== ccu_step.sv
// One calculation step: folds eight data bits, msb first, into the remainder
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"
module ccu_step (
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  data_in,
    output logic      [31:0] crc_out
);
    import ccu_pkg::*;

    always_comb begin
        logic [31:0] c;
        c = crc_in;
        for (int i = `CCU_BITS_PER_STEP - 1; i >= 0; i--) begin
            if (c[31] ^ data_in[i]) begin
                c = {c[30:0], 1'b0} ^ `CCU_POLY;
            end else begin
                c = {c[30:0], 1'b0};
            end
        end
        crc_out = c;
    end
endmodule
`default_nettype wire

// ===== ccu_top.sv
// Checksum accumulator unit: AHB slave, input buffer and four-cycle calculation
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"
module ccu_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    import ccu_pkg::*;

    // ------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------
    ccu_req_s   req_reg;
    logic       req_valid_reg;
    logic       addr_hit;
    logic       data_phase;

    assign addr_hit = (haddr & `CCU_ADDR_MASK) == `CCU_BASE_ADDR;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_valid_reg <= 1'b0;
            req_reg       <= '0;
        end else if (hready) begin
            req_valid_reg <= hsel && addr_hit && htrans[1] && (hsize == `CCU_HSIZE_WORD);
            req_reg.write <= hwrite;
            req_reg.addr  <= haddr - `CCU_BASE_ADDR;
        end
    end

    assign data_phase = req_valid_reg;

    logic wr_acc;
    logic wr_scratch;
    logic wr_ctrl;
    assign wr_acc     = data_phase && req_reg.write && (req_reg.addr == `CCU_OFS_ACC);
    assign wr_scratch = data_phase && req_reg.write && (req_reg.addr == `CCU_OFS_SCRATCH);
    assign wr_ctrl    = data_phase && req_reg.write && (req_reg.addr == `CCU_OFS_CTRL);

    // ------------------------------------------------------------
    // Input buffer and calculation
    // ------------------------------------------------------------
    ccu_state_e  state_reg;
    logic [31:0] acc_reg;
    logic [31:0] work_reg;
    logic [31:0] buf_reg;
    logic [2:0]  cnt_reg;
    logic [31:0] step_out;
    logic [7:0]  step_byte;
    logic        reinit;

    assign reinit    = wr_ctrl && hwdata[`CCU_CTRL_REINIT];
    assign step_byte = buf_reg[31:24];

    ccu_step u_step (
        .crc_in  (work_reg),
        .data_in (step_byte),
        .crc_out (step_out)
    );

    // word captured into buffer, bus never stalls
    // A word written before the last step replaces the bytes still to be folded
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_reg <= '0;
        end else if (wr_acc) begin
            buf_reg <= hwdata;
        end else if (state_reg == CCU_CALC) begin
            buf_reg <= {buf_reg[23:0], 8'h00};
        end
    end

    // ------------------------------------------------------------
    // Calculation sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CCU_IDLE;
            cnt_reg   <= '0;
        end else begin
            unique case (state_reg)
                CCU_IDLE: begin
                    if (wr_acc) begin
                        state_reg <= CCU_CALC;
                        cnt_reg   <= `CCU_CALC_CYCLES;
                    end
                end
                CCU_CALC: begin
                    cnt_reg <= cnt_reg - 3'h1;
                    if (reinit) begin
                        state_reg <= CCU_IDLE;
                    end else if (cnt_reg == 3'h1) begin
                        if (wr_acc) begin
                            // next word chains on the result just made
                            cnt_reg <= `CCU_CALC_CYCLES;
                        end else begin
                            state_reg <= CCU_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= CCU_IDLE;
                end
            endcase
        end
    end

    // Work register runs one byte per cycle during the calculation
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            work_reg <= `CCU_ACC_RESET;
        end else if (state_reg == CCU_IDLE) begin
            work_reg <= reinit ? `CCU_ACC_RESET : acc_reg;
        end else begin
            work_reg <= step_out;
        end
    end

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= `CCU_ACC_RESET;
        end else if (reinit) begin
            acc_reg <= `CCU_ACC_RESET;
        end else if (state_reg == CCU_CALC && cnt_reg == 3'h1) begin
            acc_reg <= step_out;
        end
    end

    // ------------------------------------------------------------
    // Scratch byte
    // ------------------------------------------------------------
    logic [7:0] scratch_byte_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scratch_byte_reg <= `CCU_SCRATCH_RESET;
        end else if (wr_scratch) begin
            scratch_byte_reg <= hwdata[`CCU_SCRATCH_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // Read data and response
    // ------------------------------------------------------------
    logic [31:0] rdata_next;
    logic        rd_now;
    logic [31:0] rd_ofs;

    assign rd_now = hready && hsel && addr_hit && htrans[1] && !hwrite &&
                    (hsize == `CCU_HSIZE_WORD);
    assign rd_ofs = haddr - `CCU_BASE_ADDR;

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (rd_now) begin
            unique case (rd_ofs)
                `CCU_OFS_ACC:     rdata_next = acc_reg;
                `CCU_OFS_SCRATCH: rdata_next = {24'h00_0000, scratch_byte_reg};
                // Control bit self-clears, so it always reads zero
                default:          rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else if (hready) begin
            hrdata <= rdata_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== ccu_top_properties.sv
// Concurrent checks on the checksum unit bus ports
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"
module ccu_top_properties (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp
);
    wire logic rq  = hready && hsel && htrans[1] && !hwrite;
    wire logic wok = hready && hsel && htrans[1] && hsize == `CCU_HSIZE_WORD;
    wire logic rd_acc = wok && !hwrite && haddr == `CCU_BASE_ADDR;
    logic      touched_reg;
    // Any accepted write may move the accumulator away from its reset value
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) touched_reg <= 1'b0;
        else if (wok && hwrite) touched_reg <= 1'b1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence ctrl_set;
        wok && hwrite && haddr == `CCU_BASE_ADDR + `CCU_OFS_CTRL ##1 hwdata[0];
    endsequence
    AST_READY: assert property (hreadyout) else $error("wait state inserted");
    AST_OKAY: assert property (!hresp) else $error("error response given");
    AST_RST: assert property (rd_acc && !touched_reg |=> hrdata == `CCU_ACC_RESET)
        else $error("accumulator not all ones after reset");
    AST_REINIT: assert property (ctrl_set ##1 rd_acc |=> hrdata == `CCU_ACC_RESET)
        else $error("reinit did not reload ones");
    AST_CTRL_RD: assert property (wok && rq && haddr == `CCU_BASE_ADDR + `CCU_OFS_CTRL
        |=> hrdata == 32'h0) else $error("control bit not self cleared");
    AST_SCR_HI: assert property (wok && rq && haddr == `CCU_BASE_ADDR + `CCU_OFS_SCRATCH
        |=> hrdata[31:8] == 24'h0) else $error("scratch upper bits not zero");
    AST_OFF_C: assert property (wok && rq && haddr == `CCU_BASE_ADDR + 32'hC
        |=> hrdata == 32'h0) else $error("unmapped offset read not zero");
    AST_NARROW: assert property (rq && hsize != `CCU_HSIZE_WORD |=> hrdata == 32'h0)
        else $error("narrow read answered");
endmodule
bind ccu_top ccu_top_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ===== ccu_master_model.sv
// Bus master model issuing single transfers to the checksum unit
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"
module ccu_master_model (
    input  wire logic        ref_clk,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    output logic             hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        hready = 1'b1;
    end
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        input logic [2:0] sz, output logic [31:0] r);
        {hsel, haddr, hwrite, hsize, htrans} <= {1'b1, a, w, sz, `CCU_HTRANS_NONSEQ};
        hwdata <= ~hwdata;
        @(posedge ref_clk);
        {hsel, htrans} <= 3'h0;
        hwdata <= w ? d : ~hwdata;
        @(posedge ref_clk);
        r = hrdata;
    endtask
endmodule
`default_nettype wire

// ===== crc32_calc_unit_tb.sv
// Self-checking bench of the checksum unit
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"
module crc32_calc_unit_tb;
    localparam logic [31:0] ACC = `CCU_BASE_ADDR + `CCU_OFS_ACC;
    localparam logic [31:0] SCR = `CCU_BASE_ADDR + `CCU_OFS_SCRATCH;
    localparam logic [31:0] CTL = `CCU_BASE_ADDR + `CCU_OFS_CTRL;
    localparam logic [2:0]  W   = `CCU_HSIZE_WORD;
    logic        ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, r, acc, seed, w;
    int          fail_count, checks, cyc;
    ccu_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    ccu_master_model m (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
    // Expected remainder: msb first, no reflection, no final inversion
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
        c = c ^ d;
        for (int k = 0; k < 32; k++) c = c[31] ? (c << 1) ^ `CCU_POLY : c << 1;
        return c;
    endfunction
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task rdc(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] exp);
        m.xfer(1'b0, a, 32'h0, sz, r);
        checks++;
        if (r !== exp) begin
            fail_count++;
            $display("[FAIL] %0t read %h got %h exp %h", $time, a, r, exp);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        m.xfer(1'b1, a, d, W, r);
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            $display("[FAIL] %0t timeout", $time);
            stop_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        seed = 32'd89;
        acc = `CCU_ACC_RESET;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rdc(ACC, W, `CCU_ACC_RESET);
        rdc(SCR, W, 32'h0);
        rdc(CTL, W, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 12; i++) begin
            w = (i == 0) ? 32'h0 : rnd();
            wr(ACC, w);
            rdc(ACC, W, acc);
            acc = crc_step(acc, w);
            repeat (2) @(posedge ref_clk);
            rdc(ACC, W, acc);
        end
        w = rnd();
        wr(ACC, w);
        acc = crc_step(acc, w);
        repeat (2) @(posedge ref_clk);
        w = rnd();
        wr(ACC, w);
        acc = crc_step(acc, w);
        repeat (4) @(posedge ref_clk);
        rdc(ACC, W, acc);
        $display("accumulation done");
        m.xfer(1'b1, ACC, rnd(), 3'h1, r);
        repeat (3) @(posedge ref_clk);
        rdc(ACC, W, acc);
        rdc(ACC, 3'h0, 32'h0);
        rdc(`CCU_BASE_ADDR + 32'hC, W, 32'h0);
        $display("refusals done");
        w = rnd();
        wr(SCR, {24'h0, w[7:0]});
        wr(ACC, rnd());
        wr(CTL, 32'h1);
        rdc(ACC, W, `CCU_ACC_RESET);
        rdc(SCR, W, {24'h0, w[7:0]});
        rdc(CTL, W, 32'h0);
        repeat (4) @(posedge ref_clk);
        rdc(ACC, W, `CCU_ACC_RESET);
        $display("reinit done");
        stop_test();
    end
endmodule
`default_nettype wire
